// ===== dv/dma_channel_address_counter_test.sv
`timescale 1ns/1ns
module dma_channel_address_counter_test
   import dmac_pkg::*;
;
   logic        sys_clk_i = 1'b0;
   logic        nrst_i    = 1'b0;
   logic [11:0] addr_r    = 12'h000;
   logic [7:0]  wdat_r    = 8'h00;
   logic        wr_r      = 1'b0;
   logic        rd_r      = 1'b0;
   logic        trig_r    = 1'b0;
   logic        ce_r      = 1'b1;
   logic [3:0]  lat_r     = 4'h0;
   logic [31:0] seed      = 32'h0000537F;
   logic [7:0]  rd_data_o;
   logic [11:0] xfer_addr_o;
   logic        xfer_done_i;
   logic        xfer_req_o;
   logic        xfer_word_o;
   logic        xfer_last_o;
   logic        chan_en_o;
   logic        irq_o;
   int          fail_count  = 0;
   int          check_count = 0;
   int          hi, st, el, ctl, cur, stat, mask, k, s, e;

   always #10 sys_clk_i = ~sys_clk_i;

   dmac_chan DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .ce_i(ce_r), .addr_i(addr_r),
      .wr_data_i(wdat_r), .wr_i(wr_r), .rd_i(rd_r), .rd_data_o(rd_data_o),
      .trig_i(trig_r), .xfer_done_i(xfer_done_i), .xfer_req_o(xfer_req_o),
      .xfer_addr_o(xfer_addr_o), .xfer_word_o(xfer_word_o), .xfer_last_o(xfer_last_o),
      .chan_en_o(chan_en_o), .irq_o(irq_o));

   dmac_partner far_end (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .req_i(xfer_req_o),
      .lat_i(lat_r), .done_o(xfer_done_i));

   // --------------------------------
   // reference model and bus helpers
   // --------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic int end_a();
      return ((hi >> 4) << 8) | el;
   endfunction

   function automatic logic [7:0] exp_rd(input logic [11:0] a);
      case (a)
         OFF_CTL:   return ctl[7:0];
         OFF_HI:    return 8'((hi & 8'hF0) | (cur >> 8));
         OFF_START: return 8'(cur);
         OFF_END:   return el[7:0];
         OFF_STAT:  return stat[7:0];
         OFF_MASK:  return mask[7:0];
         default:   return 8'h00;
      endcase
   endfunction

   // outputs are read 1 ns past the edge, once its updates have landed
   task automatic tick();
      @(posedge sys_clk_i);
      #1;
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      addr_r <= a;
      wdat_r <= d;
      wr_r <= 1'b1;
      tick();
      wr_r <= 1'b0;
      case (a)
         OFF_CTL:   ctl = d & CTL_WMASK;
         OFF_HI:    hi = d;
         OFF_START: st = d;
         OFF_END:   el = d;
         OFF_STAT:  stat = stat & ~(d & STAT_WMASK);
         OFF_MASK:  mask = d & STAT_WMASK;
         default:   ;
      endcase
      if (a == OFF_HI || a == OFF_START)
         cur = ((hi & 15) << 8) | st;
      tick();
      chk_bit(irq_o, stat[0] & mask[0]);
   endtask

   task automatic rd(input logic [11:0] a);
      logic [7:0] x;
      x = exp_rd(a);
      addr_r <= a;
      rd_r <= 1'b1;
      tick();
      rd_r <= 1'b0;
      chk_val(rd_data_o, x);
      tick();
   endtask

   task automatic xfer(input logic [3:0] lat);
      int n;
      logic wd;
      logic lst;
      wd = ctl[CTL_WORD_SELECT_BIT];
      lst = (cur == end_a()) || (wd && ((cur + 1) % 4096) == end_a());
      lat_r <= lat;
      trig_r <= 1'b1;
      tick();
      trig_r <= 1'b0;
      for (n = 0; n < 8 && xfer_req_o !== 1'b1; n++)
         tick();
      chk_bit(xfer_req_o, 1'b1);
      chk_val(xfer_addr_o, cur[11:0]);
      chk_bit(xfer_word_o, wd);
      chk_bit(xfer_last_o, lst);
      for (n = 0; n < 40 && xfer_req_o === 1'b1; n++)
         tick();
      if (lst)
      begin
         cur = ((hi & 15) << 8) | st;
         if (!ctl[CTL_LOOP_BIT])
            ctl[CTL_EN_BIT] = 1'b0;
         if (ctl[CTL_IRQ_BIT])
            stat = 1;
      end
      else
         cur = (cur + (wd ? 2 : 1)) % 4096;
      chk_bit(chan_en_o, ctl[CTL_EN_BIT]);
      chk_bit(irq_o, stat[0] & mask[0]);
      rd(OFF_START);
   endtask

   initial
   begin
      #200000;
      fail_count++;
      wrap_up();
   end

   // --------------------------------
   // test sequence
   // --------------------------------
   initial
   begin
      {hi, st, el, ctl, cur, stat, mask} = '0;
      repeat (4) tick();
      nrst_i <= 1'b1;
      tick();
      for (k = 0; k < 8; k++)
         rd(OFF_CTL + k[11:0]);
      $display("test reset done");
      // byte pass across a nibble carry, single pass, irq unmasked
      wr(OFF_HI, 8'h21);
      wr(OFF_START, 8'hFE);
      wr(OFF_END, 8'h01);
      wr(OFF_MASK, 8'h01);
      wr(OFF_CTL, 8'h90);
      rd(OFF_HI);
      for (k = 0; k < 4; k++)
         xfer(4'(rnd() & 3));
      rd(OFF_HI);
      rd(OFF_CTL);
      trig_r <= 1'b1;
      tick();
      trig_r <= 1'b0;
      repeat (3) tick();
      chk_bit(xfer_req_o, 1'b0);
      wr(OFF_STAT, 8'h01);
      $display("test byte pass done");
      // word mode, looping, random placement, irq masked then disabled
      s = rnd() % 4000;
      e = s + 3;
      wr(OFF_HI, 8'(((e >> 8) << 4) | (s >> 8)));
      wr(OFF_START, 8'(s));
      wr(OFF_END, 8'(e));
      wr(OFF_MASK, 8'h00);
      wr(OFF_CTL, 8'hD8);
      for (k = 0; k < 5; k++)
         xfer(4'(rnd() & 7));
      rd(OFF_STAT);
      wr(OFF_MASK, 8'h01);
      wr(OFF_STAT, 8'h01);
      wr(OFF_CTL, 8'hC8);
      for (k = 0; k < 2; k++)
         xfer(4'(rnd() & 3));
      // frozen clock enable: a trigger and a read are both lost
      ce_r <= 1'b0;
      trig_r <= 1'b1;
      addr_r <= OFF_START;
      rd_r <= 1'b1;
      tick();
      trig_r <= 1'b0;
      rd_r <= 1'b0;
      tick();
      chk_bit(xfer_req_o, 1'b0);
      chk_val(rd_data_o, 12'h000);
      ce_r <= 1'b1;
      tick();
      rd(OFF_STAT);
      $display("test word loop done");
      wrap_up();
   end
endmodule // dma_channel_address_counter_test

// ===== dv/dmac_partner.sv
`timescale 1ns/1ns
// ------------------------------------
// far side: answers lat_i+1 cycles after the request
// ------------------------------------
module dmac_partner
   import dmac_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       nrst_i,
   input  wire logic       req_i,
   input  wire logic [3:0] lat_i,
   output logic            done_o
);
   logic [3:0] wait_r;

   // one done pulse per request, never while idle
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wait_r <= 4'h0;
         done_o <= 1'b0;
      end
      else if (req_i && !done_o && wait_r >= lat_i)
      begin
         done_o <= 1'b1;
         wait_r <= 4'h0;
      end
      else
      begin
         done_o <= 1'b0;
         wait_r <= (req_i && !done_o) ? wait_r + 4'h1 : 4'h0;
      end
   end
endmodule // dmac_partner

// ===== verilog/dmac_addr_ctr.sv
`timescale 1ns/1ns
module dmac_addr_ctr
   import dmac_pkg::*;
#(
   parameter int AW = ADDR_W
)
(
   input  wire logic          sys_clk_i,
   input  wire logic          nrst_i,
   input  wire logic          ce_i,
   input  wire logic          load_i,
   input  wire logic [AW-1:0] load_val_i,
   input  wire logic          adv_i,
   input  wire logic          word_i,
   input  wire logic [AW-1:0] end_i,
   output logic      [AW-1:0] cur_o,
   output logic               last_o
);

   logic [AW-1:0] cur_r;
   logic [AW-1:0] gap;

   // a word covering the end location also closes the pass
   assign gap    = end_i - cur_r;
   assign last_o = word_i ? (gap <= AW'(STEP_BYTE)) : (gap == '0);   // see RULE10
   assign cur_o  = cur_r;

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         cur_r <= AW'(RST_ADDR);
      else if (ce_i)
      begin
         if (load_i)
            cur_r <= load_val_i;
         else if (adv_i)
            cur_r <= cur_r + (word_i ? AW'(STEP_WORD) : AW'(STEP_BYTE));   // see RULE3
      end
   end

endmodule // dmac_addr_ctr

// ===== verilog/dmac_chan.sv
// Operation
// RULE1: current address is high-nibble register bits 3:0 above the start low byte.
// RULE2: writing the start low byte sets the low byte of the start address.
// RULE3: after each transfer the 12-bit current address steps by 1 or 2.
// RULE4: reading the start low byte returns the current address low byte.
// RULE5: end address is high-nibble bits 7:4 above the end low byte.
// RULE6: after the end transfer reload start; stop unless looping is enabled.
// RULE7: word select clear moves a byte, set moves a two-byte word.
// RULE8: with interrupt enable set, the end transfer raises an interrupt.
// RULE9: disabled channel ignores triggers; enabled, each trigger starts one transfer. Here a trigger that arrives while a transfer is busy is dropped.
// RULE10: compare current and end before each transfer to find the last one.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
module dmac_chan
   import dmac_pkg::*;
(
   input  wire logic              sys_clk_i,
   input  wire logic              nrst_i,
   input  wire logic              ce_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wr_data_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [DATA_W-1:0] rd_data_o,
   input  wire logic              trig_i,
   input  wire logic              xfer_done_i,
   output logic                   xfer_req_o,
   output logic      [ADDR_W-1:0] xfer_addr_o,
   output logic                   xfer_word_o,
   output logic                   xfer_last_o,
   output logic                   chan_en_o,
   output logic                   irq_o
);

   // ---------------------------------------------------------------
   // register decode
   // ---------------------------------------------------------------
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   logic wr_ctl, wr_hi, wr_start, wr_end, wr_stat, wr_mask;

   assign wr_ctl   = wr_i && hit(addr_i, OFF_CTL);
   assign wr_hi    = wr_i && hit(addr_i, OFF_HI);
   assign wr_start = wr_i && hit(addr_i, OFF_START);
   assign wr_end   = wr_i && hit(addr_i, OFF_END);
   assign wr_stat  = wr_i && hit(addr_i, OFF_STAT);
   assign wr_mask  = wr_i && hit(addr_i, OFF_MASK);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] ctl_r;
   logic [DATA_W-1:0] addr_high_nibble_reg_r;
   logic [DATA_W-1:0] dma_current_addr_low_r;
   logic [DATA_W-1:0] dma_end_addr_low_r;
   logic [DATA_W-1:0] stat_r;
   logic [DATA_W-1:0] mask_r;
   dmac_state_t       state_r;

   logic              channel_enable, loop_enable, end_irq_enable, word_select;
   logic [ADDR_W-1:0] start_addr, end_addr, cur_addr;
   logic [ADDR_W-1:0] load_val;
   logic              load, is_last, done, fire, pass_end, word_now;
   logic [NIB_W-1:0]  start_hi_nxt;
   logic [DATA_W-1:0] start_lo_nxt;

   assign channel_enable = ctl_r[CTL_EN_BIT];
   assign loop_enable    = ctl_r[CTL_LOOP_BIT];
   assign end_irq_enable = ctl_r[CTL_IRQ_BIT];
   assign word_select    = ctl_r[CTL_WORD_SELECT_BIT];

   assign start_addr = {addr_high_nibble_reg_r[NIB_W-1:0], dma_current_addr_low_r};   // see RULE1
   assign end_addr   = {addr_high_nibble_reg_r[DATA_W-1:NIB_W], dma_end_addr_low_r}; // see RULE5

   assign fire     = ce_i && trig_i && channel_enable && (state_r == ST_IDLE);   // see RULE9
   assign done     = ce_i && xfer_done_i && (state_r == ST_BUSY);
   assign pass_end = done && xfer_last_o;
   // idle: size of the next transfer for the end test; busy: size of the one in flight
   assign word_now = (state_r == ST_BUSY) ? xfer_word_o : word_select;          // see RULE7

   // a register write beats a reload landing in the same cycle
   assign start_hi_nxt = wr_hi ? wr_data_i[NIB_W-1:0] : addr_high_nibble_reg_r[NIB_W-1:0];
   assign start_lo_nxt = wr_start ? wr_data_i : dma_current_addr_low_r;
   assign load         = wr_hi || wr_start || pass_end;
   assign load_val     = (wr_hi || wr_start) ? {start_hi_nxt, start_lo_nxt}     // see RULE2
                                             : start_addr;                      // see RULE6

   dmac_addr_ctr #(
      .AW         (ADDR_W)
   ) u_addr_ctr (
      .sys_clk_i  (sys_clk_i),
      .nrst_i     (nrst_i),
      .ce_i       (ce_i),
      .load_i     (load),
      .load_val_i (load_val),
      .adv_i      (done),
      .word_i     (word_now),
      .end_i      (end_addr),
      .cur_o      (cur_addr),
      .last_o     (is_last)
   );

   // ---------------------------------------------------------------
   // address registers
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         addr_high_nibble_reg_r <= RST_BYTE;
         dma_current_addr_low_r <= RST_BYTE;
         dma_end_addr_low_r     <= RST_BYTE;
      end
      else if (ce_i)
      begin
         if (wr_hi)
            addr_high_nibble_reg_r <= wr_data_i;
         if (wr_start)
            dma_current_addr_low_r <= wr_data_i;
         if (wr_end)
            dma_end_addr_low_r <= wr_data_i;
      end
   end

   // ---------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         ctl_r <= RST_BYTE;
      else if (ce_i)
      begin
         if (wr_ctl)
            ctl_r <= wr_data_i & CTL_WMASK;
         else if (pass_end && !loop_enable)
            ctl_r[CTL_EN_BIT] <= 1'b0;                                   // see RULE6
      end
   end

   // ---------------------------------------------------------------
   // transfer sequencing
   // ---------------------------------------------------------------
   // triggers during a busy transfer are dropped, not queued
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_r     <= ST_IDLE;
         xfer_req_o  <= 1'b0;
         xfer_addr_o <= RST_ADDR;
         xfer_word_o <= 1'b0;
         xfer_last_o <= 1'b0;
      end
      else if (ce_i)
      begin
         unique case (state_r)
            ST_IDLE:
            begin
               if (fire)
               begin
                  state_r     <= ST_BUSY;
                  xfer_req_o  <= 1'b1;                                   // see RULE9
                  xfer_addr_o <= cur_addr;
                  xfer_word_o <= word_select;                            // see RULE7
                  xfer_last_o <= is_last;                                // see RULE10
               end
            end
            ST_BUSY:
            begin
               if (xfer_done_i)
               begin
                  state_r    <= ST_IDLE;
                  xfer_req_o <= 1'b0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         chan_en_o <= 1'b0;
      else if (ce_i)
         chan_en_o <= wr_ctl ? wr_data_i[CTL_EN_BIT]
                             : channel_enable && !(pass_end && !loop_enable);
   end

   // ---------------------------------------------------------------
   // interrupt status and mask
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] stat_set, stat_nxt;

   assign stat_set = {{(DATA_W-1){1'b0}}, pass_end && end_irq_enable};    // see RULE8
   // a new event wins over a write-one-to-clear in the same cycle
   assign stat_nxt = (stat_r & ~(wr_stat ? (wr_data_i & STAT_WMASK) : RST_BYTE)) | stat_set;

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         stat_r <= RST_BYTE;
         mask_r <= RST_BYTE;
         irq_o  <= 1'b0;
      end
      else if (ce_i)
      begin
         stat_r <= stat_nxt;
         if (wr_mask)
            mask_r <= wr_data_i & STAT_WMASK;
         irq_o <= |(stat_nxt & (wr_mask ? (wr_data_i & STAT_WMASK) : mask_r));
      end
   end

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   // unmapped addresses read zero; data stand for one cycle only
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rd_data_o <= RST_BYTE;
      else if (ce_i)
      begin
         rd_data_o <= RST_BYTE;
         if (rd_i)
         begin
            if (hit(addr_i, OFF_CTL))
               rd_data_o <= ctl_r;
            else if (hit(addr_i, OFF_HI))
               rd_data_o <= {addr_high_nibble_reg_r[DATA_W-1:NIB_W],
                             cur_addr[ADDR_W-1:DATA_W]};
            else if (hit(addr_i, OFF_START))
               rd_data_o <= cur_addr[DATA_W-1:0];                        // see RULE4
            else if (hit(addr_i, OFF_END))
               rd_data_o <= dma_end_addr_low_r;
            else if (hit(addr_i, OFF_STAT))
               rd_data_o <= stat_r;
            else if (hit(addr_i, OFF_MASK))
               rd_data_o <= mask_r;
         end
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   a_start_compose: assert property (  // see RULE1
      ce_i && wr_start && !wr_hi |=> cur_addr == {$past(addr_high_nibble_reg_r[NIB_W-1:0]),
                                                  $past(wr_data_i)})
      else $error("start write did not form current address");

   a_start_reload: assert property (  // see RULE6
      pass_end && !wr_hi && !wr_start
      |=> cur_addr == $past({addr_high_nibble_reg_r[NIB_W-1:0], dma_current_addr_low_r}))
      else $error("reload did not return to written start");

   a_step_size: assert property (  // see RULE3
      done && !xfer_last_o && !wr_hi && !wr_start
      |=> cur_addr == $past(cur_addr) + (xfer_word_o ? STEP_WORD : STEP_BYTE))
      else $error("current address stepped wrongly");

   a_read_current: assert property (  // see RULE4
      ce_i && rd_i && hit(addr_i, OFF_START) |=> rd_data_o == $past(cur_addr[DATA_W-1:0]))
      else $error("start read did not return current address");

   a_end_detect: assert property (  // see RULE5
      fire && !xfer_word_o && !word_select |=> xfer_last_o == ($past(cur_addr) ==
                                                $past(end_addr)))
      else $error("end address compare wrong");

   a_pass_stop: assert property (  // see RULE6
      pass_end && !loop_enable && !wr_ctl |=> !chan_en_o && !channel_enable)
      else $error("single pass did not disable channel");

   a_loop_run: assert property (  // see RULE6
      pass_end && loop_enable && channel_enable && !wr_ctl |=> chan_en_o)
      else $error("loop mode dropped enable");

   a_word_flag: assert property (  // see RULE7
      fire |=> xfer_req_o && xfer_word_o == $past(word_select)
               && xfer_addr_o == $past(cur_addr))
      else $error("transfer size or address not taken");

   a_irq_end: assert property (  // see RULE8
      pass_end && end_irq_enable |=> stat_r[STAT_END_BIT])
      else $error("end interrupt not raised");

   a_irq_quiet: assert property (  // see RULE8
      ce_i && !stat_r[STAT_END_BIT] ##1 stat_r[STAT_END_BIT]
      |-> $past(pass_end) && $past(end_irq_enable))
      else $error("interrupt raised without cause");

   a_trig_ignored: assert property (  // see RULE9
      !xfer_req_o ##1 xfer_req_o |-> $past(trig_i) && $past(channel_enable))
      else $error("transfer started without enabled trigger");

   a_last_wait: assert property (  // see RULE10
      xfer_req_o && !done |=> xfer_req_o && $stable(xfer_last_o) && $stable(xfer_addr_o))
      else $error("request dropped or changed while waiting");

   c_byte_xfer: cover property (done && !xfer_word_o);
   c_word_xfer: cover property (done && xfer_word_o);
   c_loop_end:  cover property (pass_end && loop_enable);
   c_irq_fire:  cover property (!irq_o ##1 irq_o);

endmodule // dmac_chan

// ===== verilog/dmac_pkg.sv
package dmac_pkg;

   // ---------------------------------------------------------------
   // widths
   // ---------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int NIB_W  = 4;

   // ---------------------------------------------------------------
   // register offsets
   // ---------------------------------------------------------------
   localparam logic [11:0] OFF_CTL   = 12'hFB0;
   localparam logic [11:0] OFF_HI    = 12'hFB2;
   localparam logic [11:0] OFF_START = 12'hFB3;
   localparam logic [11:0] OFF_END   = 12'hFB4;
   localparam logic [11:0] OFF_STAT  = 12'hFB5;
   localparam logic [11:0] OFF_MASK  = 12'hFB6;

   // ---------------------------------------------------------------
   // control and status field positions and masks
   // ---------------------------------------------------------------
   localparam int          CTL_EN_BIT   = 7;
   localparam int          CTL_LOOP_BIT = 6;
   localparam int          CTL_IRQ_BIT  = 4;
   localparam int          CTL_WORD_SELECT_BIT = 3;
   localparam logic [7:0]  CTL_WMASK    = 8'hD8;
   localparam int          STAT_END_BIT = 0;
   localparam logic [7:0]  STAT_WMASK   = 8'h01;

   // ---------------------------------------------------------------
   // reset values and steps
   // ---------------------------------------------------------------
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [11:0] RST_ADDR  = 12'h000;
   localparam logic [11:0] STEP_BYTE = 12'h001;
   localparam logic [11:0] STEP_WORD = 12'h002;

   typedef enum logic {
      ST_IDLE,
      ST_BUSY
   } dmac_state_t;

endpackage
